// ===== logic/btseq_pkg.sv
// constants, types and register map of the buffer transmit sequencer
// ---------------------------------------------------------------
// Overview of operation
// - a four-bit state register holds one of ten states steering outputs
// - power-up, page, home, reset or escape force the idle state 1000
// - starting enter or send enters first-left 1001, one left step
// - seek-left 0000 keeps stepping left every move phase until a stop
// - at left margin 0001 stores lower-case o, jumps right, steps up
// - at a CR or ETX separator 0010 steps right, then sending starts
// - reaching home with no separator starts sending at once
// - a separator in the last column gives column clear plus row down
// - sending 0011 transmits in read phase, steps right in move phase
// - a transmittable field code sends US first, then the code itself
// - a non-transmittable field code and its field are never sent
// - end of line 0101 clears column, steps down, sends CR if data
// - with line feed configured 0110 sends LF after a CR
// - closing separator or last position: 0111 sends end char, to idle
// - a keyboard enter stores ETX at the cursor before searching left
// - row counter steps down or up in the move phase
// - last row, 24 or optionally 12, raises a flag and blocks down
// - top row raises a flag and blocks up requests
// - column counter steps right, blocked with a flag at line end
// - column counter steps left, blocked with a flag at left margin
// - row clear or column clear zeroes its counter in the move phase
// - counters take a preset on load; clear forces zero over all
// - line feed generation and end character come from configuration
// ---------------------------------------------------------------
package btseq_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CMD    = 8'h00;
	localparam logic [7:0] ADDR_CFG    = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_CURSOR = 8'h0C;
	localparam logic [7:0] ADDR_TXLAST = 8'h10;
	// command bits
	localparam int CMD_SEND  = 0;
	localparam int CMD_ENTER = 1;
	localparam int CMD_KBD   = 2;
	localparam int CMD_PAGE  = 3;
	localparam int CMD_HOME  = 4;
	localparam int CMD_RESET = 5;
	localparam int CMD_ESC   = 6;
	// configuration and cursor fields
	localparam int CFG_LF     = 0;
	localparam int CFG_ROWS12 = 1;
	localparam int CFG_END_LSB = 8;
	localparam int CUR_Y_LSB  = 8;
	localparam logic [7:0] END_CHAR_RST = 8'h0D;
	// geometry
	localparam logic [6:0] LAST_COL    = 7'h4F;
	localparam logic [4:0] LAST_ROW_24 = 5'h17;
	localparam logic [4:0] LAST_ROW_12 = 5'h0B;
	// character codes
	localparam logic [7:0] CH_NUL     = 8'h00;
	localparam logic [7:0] CH_ETX     = 8'h03;
	localparam logic [7:0] CH_LF      = 8'h0A;
	localparam logic [7:0] CH_CR      = 8'h0D;
	localparam logic [7:0] CH_US      = 8'h1F;
	localparam logic [7:0] CH_LOWER_O = 8'h6F;
	typedef enum logic [3:0] {
		ST_INIT     = 4'h8,
		ST_LEFT_ONE = 4'h9,
		ST_SEEK     = 4'h0,
		ST_STUFF    = 4'h1,
		ST_OFF_SEP  = 4'h2,
		ST_SEND     = 4'h3,
		ST_FIELD    = 4'h4,
		ST_EOL_CR   = 4'h5,
		ST_EOL_LF   = 4'h6,
		ST_END      = 4'h7
	} btseq_state_t;
	typedef enum logic [2:0] {
		PH_STORE = 3'b001,
		PH_READ  = 3'b010,
		PH_MOVE  = 3'b100
	} btseq_phase_t;
endpackage

// ===== logic/btseq_top.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// buffer transmit sequencer: cursor counters, state machine, apb registers

// ---------------------------------------------------------------
// position counter
// ---------------------------------------------------------------
module btseq_counter #(
	parameter int W = 7
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// requests
	input  wire logic         inc,
	input  wire logic         dec,
	input  wire logic         clr,
	input  wire logic         load,
	input  wire logic [W-1:0] preset,
	input  wire logic [W-1:0] limit,
	// count and flags
	output logic      [W-1:0] count_q,
	output logic              at_top,
	output logic              at_zero
);
	assign at_top  = (count_q >= limit);
	assign at_zero = (count_q == '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
		end else if (clr) begin
			count_q <= '0;
		end else if (load) begin
			count_q <= preset;
		end else if (inc && !at_top) begin
			count_q <= count_q + 1'b1;
		end else if (dec && !at_zero) begin
			count_q <= count_q - 1'b1;
		end
	end
endmodule

// ---------------------------------------------------------------
// sequencer top
// ---------------------------------------------------------------
module btseq_top import btseq_pkg::*; (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// character buffer
	output logic      [6:0]  buf_col,
	output logic      [4:0]  buf_row,
	input  wire logic [7:0]  buf_rdata,
	input  wire logic        buf_is_fac,
	input  wire logic        buf_fac_xmit,
	output logic             store_strobe,
	output logic      [7:0]  store_data,
	// host interface unit
	output logic             transmit_strobe,
	output logic      [7:0]  tx_char
);
	btseq_state_t state_q;
	btseq_state_t state_d;
	btseq_phase_t phase_q;
	logic         move_phase;
	logic [7:0]   char_q;
	logic         fac_q;
	logic         fac_done_q;
	logic         hidden_q;
	logic         line_data_q;
	logic         kbd_q;
	logic         start_pend_q;
	logic         home_pend_q;
	logic         lf_en_q;
	logic         rows12_q;
	logic [7:0]   end_char_q;
	logic [31:0]  prdata_q;
	logic [31:0]  rd_val;
	logic         hit;
	logic         wr;
	logic         cmd_wr;
	logic         cur_wr;
	logic         force_idle;
	logic         start_req;
	logic         left_req;
	logic         right_req;
	logic         up_req;
	logic         down_req;
	logic         column_clear;
	logic         row_clear;
	logic         right_margin_jump;
	logic         top_row_flag;
	logic         last_row_flag;
	logic         line_end_flag;
	logic         left_margin_flag;
	logic         is_sep;
	logic         fac_new;
	logic         at_home;
	logic         seek_stop;
	logic         send_stop;
	logic         send_ok;
	logic         tx_d;
	logic [7:0]   tx_char_d;
	logic         store_d;
	logic [4:0]   row_limit;

	// ---------------------------------------------------------------
	// apb slave
	// ---------------------------------------------------------------
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = psel && penable && !hit;
	assign wr      = psel && penable && pwrite && hit;
	assign cmd_wr  = wr && (paddr == ADDR_CMD);
	// cursor preset only while idle, so it never fights the sequencer
	assign cur_wr  = wr && (paddr == ADDR_CURSOR) && (state_q == ST_INIT);
	assign force_idle = cmd_wr && (pwdata[CMD_PAGE] || pwdata[CMD_HOME]
		|| pwdata[CMD_RESET] || pwdata[CMD_ESC]);
	assign start_req = cmd_wr && (pwdata[CMD_SEND] || pwdata[CMD_ENTER])
		&& (state_q == ST_INIT) && !force_idle;

	always_comb begin
		rd_val = 32'h0000_0000;
		hit    = 1'b1;
		if (paddr == ADDR_CMD) begin
			rd_val = 32'h0000_0000;
		end else if (paddr == ADDR_CFG) begin
			rd_val[CFG_LF]     = lf_en_q;
			rd_val[CFG_ROWS12] = rows12_q;
			rd_val[CFG_END_LSB +: 8] = end_char_q;
		end else if (paddr == ADDR_STATUS) begin
			rd_val[3:0] = state_q;
			rd_val[4]   = (state_q != ST_INIT) || start_pend_q;
			rd_val[5]   = top_row_flag;
			rd_val[6]   = last_row_flag;
			rd_val[7]   = left_margin_flag;
			rd_val[8]   = line_end_flag;
			rd_val[9]   = hidden_q;
			rd_val[10]  = line_data_q;
		end else if (paddr == ADDR_CURSOR) begin
			rd_val[6:0] = buf_col;
			rd_val[CUR_Y_LSB +: 5] = buf_row;
		end else if (paddr == ADDR_TXLAST) begin
			rd_val[7:0] = tx_char;
		end else begin
			hit = 1'b0;
		end
	end

	// read data is fetched in the setup cycle, so the access needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata_q <= rd_val;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lf_en_q    <= 1'b0;
			rows12_q   <= 1'b0;
			end_char_q <= END_CHAR_RST;
		end else if (wr && (paddr == ADDR_CFG)) begin
			lf_en_q    <= pwdata[CFG_LF];
			rows12_q   <= pwdata[CFG_ROWS12];
			end_char_q <= pwdata[CFG_END_LSB +: 8];
		end
	end

	// ---------------------------------------------------------------
	// character cycle phases
	// ---------------------------------------------------------------
	assign move_phase = (phase_q == PH_MOVE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= PH_STORE;
		end else begin
			case (phase_q)
				PH_STORE: phase_q <= PH_READ;
				PH_READ:  phase_q <= PH_MOVE;
				default:  phase_q <= PH_STORE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// cursor counters
	// ---------------------------------------------------------------
	assign row_limit = rows12_q ? LAST_ROW_12 : LAST_ROW_24;

	btseq_counter #(.W(7)) u_col (
		.pclk    (pclk),
		.presetn (presetn),
		.inc     (move_phase && right_req),
		.dec     (move_phase && left_req),
		.clr     (move_phase && column_clear),
		.load    (right_margin_jump || cur_wr),
		.preset  (right_margin_jump ? LAST_COL : pwdata[6:0]),
		.limit   (LAST_COL),
		.count_q (buf_col),
		.at_top  (line_end_flag),
		.at_zero (left_margin_flag)
	);

	btseq_counter #(.W(5)) u_row (
		.pclk    (pclk),
		.presetn (presetn),
		.inc     (move_phase && down_req),
		.dec     (move_phase && up_req),
		.clr     (move_phase && row_clear),
		.load    (cur_wr),
		.preset  (pwdata[CUR_Y_LSB +: 5]),
		.limit   (row_limit),
		.count_q (buf_row),
		.at_top  (last_row_flag),
		.at_zero (top_row_flag)
	);

	// page and home put the cursor home at the next move phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			home_pend_q <= 1'b0;
		end else if (cmd_wr && (pwdata[CMD_PAGE] || pwdata[CMD_HOME])) begin
			home_pend_q <= 1'b1;
		end else if (move_phase) begin
			home_pend_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// conditions seen at the cursor
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			char_q <= CH_NUL;
			fac_q  <= 1'b0;
		end else if (phase_q == PH_READ) begin
			char_q <= buf_rdata;
			fac_q  <= buf_is_fac;
		end
	end

	assign is_sep    = (char_q == CH_CR) || (char_q == CH_ETX);
	assign fac_new   = fac_q && !fac_done_q;
	assign at_home   = left_margin_flag && top_row_flag;
	assign seek_stop = is_sep || at_home || left_margin_flag;
	assign send_stop = is_sep || fac_new || line_end_flag;
	// nuls read from the buffer are never sent: null suppression
	assign send_ok   = (buf_rdata != CH_NUL) && (buf_rdata != CH_CR)
		&& (buf_rdata != CH_ETX) && !(buf_is_fac && !fac_done_q) && !hidden_q;

	// ---------------------------------------------------------------
	// cursor requests per state
	// ---------------------------------------------------------------
	always_comb begin
		left_req          = 1'b0;
		right_req         = 1'b0;
		up_req            = 1'b0;
		down_req          = 1'b0;
		column_clear      = 1'b0;
		right_margin_jump = 1'b0;
		case (state_q)
			ST_LEFT_ONE: begin
				left_req = 1'b1;
			end
			ST_SEEK: begin
				left_req = !seek_stop;
			end
			ST_STUFF: begin
				// jump while the stored o is on the bus, so it lands at the margin
				right_margin_jump = (phase_q == PH_READ);
				up_req = 1'b1;
			end
			ST_OFF_SEP: begin
				right_req    = !line_end_flag;
				column_clear = line_end_flag;
				down_req     = line_end_flag;
			end
			ST_SEND: begin
				right_req = !send_stop;
			end
			ST_EOL_CR: begin
				column_clear = 1'b1;
				down_req     = 1'b1;
			end
			ST_END: begin
				column_clear = 1'b1;
			end
			default: begin
				left_req = 1'b0;
			end
		endcase
		column_clear = column_clear || home_pend_q;
		row_clear    = home_pend_q;
	end

	// ---------------------------------------------------------------
	// state register and next state
	// ---------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_INIT: begin
				if (start_pend_q) state_d = ST_LEFT_ONE;
			end
			ST_LEFT_ONE: state_d = ST_SEEK;
			ST_SEEK: begin
				if (is_sep) begin
					state_d = ST_OFF_SEP;
				end else if (at_home) begin
					state_d = ST_SEND;
				end else if (left_margin_flag) begin
					state_d = ST_STUFF;
				end
			end
			ST_STUFF:   state_d = ST_SEEK;
			ST_OFF_SEP: state_d = ST_SEND;
			ST_SEND: begin
				if (is_sep) begin
					state_d = ST_END;
				end else if (fac_new) begin
					state_d = ST_FIELD;
				end else if (line_end_flag && last_row_flag) begin
					state_d = ST_END;
				end else if (line_end_flag) begin
					state_d = ST_EOL_CR;
				end
			end
			ST_FIELD:  state_d = ST_SEND;
			ST_EOL_CR: state_d = (lf_en_q && line_data_q) ? ST_EOL_LF : ST_SEND;
			ST_EOL_LF: state_d = ST_SEND;
			ST_END:    state_d = ST_INIT;
			default:   state_d = ST_INIT;
		endcase
	end

	// force events win over the character cycle from any state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_INIT;
		end else if (force_idle) begin
			state_q <= ST_INIT;
		end else if (move_phase) begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_pend_q <= 1'b0;
			kbd_q        <= 1'b0;
		end else if (force_idle) begin
			start_pend_q <= 1'b0;
			kbd_q        <= 1'b0;
		end else if (start_req) begin
			start_pend_q <= 1'b1;
			kbd_q        <= pwdata[CMD_ENTER] && pwdata[CMD_KBD];
		end else if (move_phase && state_q == ST_INIT) begin
			start_pend_q <= 1'b0;
		end else if (move_phase && state_q == ST_LEFT_ONE) begin
			kbd_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// field and line bookkeeping
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hidden_q   <= 1'b0;
			fac_done_q <= 1'b0;
		end else if (force_idle || state_q == ST_INIT) begin
			hidden_q   <= 1'b0;
			fac_done_q <= 1'b0;
		end else if (state_q == ST_FIELD) begin
			if (phase_q == PH_READ) hidden_q <= !buf_fac_xmit;
			if (move_phase) fac_done_q <= 1'b1;
		end else if (move_phase && right_req) begin
			fac_done_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_data_q <= 1'b0;
		end else if (state_q == ST_SEND && phase_q == PH_READ && send_ok) begin
			line_data_q <= 1'b1;
		end else if (state_q == ST_INIT || (state_q == ST_EOL_CR && move_phase)) begin
			line_data_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// transmit and store outputs
	// ---------------------------------------------------------------
	always_comb begin
		tx_d      = 1'b0;
		tx_char_d = buf_rdata;
		case (state_q)
			ST_SEND: begin
				tx_d = (phase_q == PH_READ) && send_ok;
			end
			ST_FIELD: begin
				tx_d      = (phase_q == PH_READ) && buf_fac_xmit;
				tx_char_d = CH_US;
			end
			ST_EOL_CR: begin
				tx_d      = (phase_q == PH_STORE) && line_data_q;
				tx_char_d = CH_CR;
			end
			ST_EOL_LF: begin
				tx_d      = (phase_q == PH_STORE);
				tx_char_d = CH_LF;
			end
			ST_END: begin
				tx_d      = (phase_q == PH_STORE);
				tx_char_d = end_char_q;
			end
			default: begin
				tx_d = 1'b0;
			end
		endcase
	end

	assign store_d = (phase_q == PH_STORE) && (state_q == ST_STUFF
		|| (state_q == ST_LEFT_ONE && kbd_q));

	// one strobe per character, the receiver takes each in turn
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transmit_strobe <= 1'b0;
			tx_char         <= CH_NUL;
		end else begin
			transmit_strobe <= tx_d && !force_idle;
			if (tx_d) tx_char <= tx_char_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_strobe <= 1'b0;
			store_data   <= CH_NUL;
		end else begin
			store_strobe <= store_d && !force_idle;
			if (store_d) store_data <= (state_q == ST_STUFF) ? CH_LOWER_O : CH_ETX;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_eol_cr_store;
		state_q == ST_EOL_CR && phase_q == PH_STORE && line_data_q && !force_idle;
	endsequence
	sequence s_cr_out;
		transmit_strobe && tx_char == CH_CR;
	endsequence
	sequence s_stuff_store;
		state_q == ST_STUFF && phase_q == PH_STORE && !force_idle;
	endsequence

	a_force_idle: assert property (force_idle |=> state_q == ST_INIT)
		else $error("force event did not reach idle");
	a_start_left: assert property (state_q == ST_INIT && start_pend_q && move_phase
		&& !force_idle |=> state_q == ST_LEFT_ONE)
		else $error("start did not enter first-left");
	a_state_hold: assert property (!move_phase && !force_idle |=> $stable(state_q))
		else $error("state changed outside move phase");
	a_seek_step: assert property (state_q == ST_SEEK && move_phase && !seek_stop
		|=> buf_col == $past(buf_col) - 7'h01)
		else $error("seek-left did not step left");
	a_stuff_jump: assert property (s_stuff_store |=> store_strobe
		&& store_data == CH_LOWER_O ##1 buf_col == LAST_COL)
		else $error("margin stuff missing");
	a_send_char: assert property (state_q == ST_SEND && phase_q == PH_READ && send_ok
		&& !force_idle |=> transmit_strobe && tx_char == $past(buf_rdata))
		else $error("character not transmitted");
	a_fac_us: assert property (state_q == ST_FIELD && phase_q == PH_READ && buf_fac_xmit
		&& !force_idle |=> transmit_strobe && tx_char == CH_US)
		else $error("US not sent before field code");
	a_hidden_quiet: assert property (hidden_q && state_q == ST_SEND |-> !tx_d)
		else $error("hidden field transmitted");
	a_eol_cr: assert property (s_eol_cr_store |=> s_cr_out)
		else $error("CR not sent at end of line");
	a_lf_after: assert property (state_q == ST_EOL_LF && phase_q == PH_STORE && !force_idle
		|=> transmit_strobe && tx_char == CH_LF)
		else $error("LF not sent");
	a_end_return: assert property (state_q == ST_END && move_phase && !force_idle
		|=> state_q == ST_INIT && buf_col == 7'h00)
		else $error("end did not return to idle at margin");
	a_etx_store: assert property (state_q == ST_LEFT_ONE && phase_q == PH_STORE && kbd_q
		&& !force_idle |=> store_strobe && store_data == CH_ETX)
		else $error("ETX not stored");
	a_top_block: assert property (top_row_flag && up_req && move_phase && !cur_wr
		|=> buf_row == 5'h00)
		else $error("row moved above top");
	a_eol_block: assert property (state_q == ST_SEND && line_end_flag && move_phase
		|=> buf_col == LAST_COL)
		else $error("column moved past line end");
endmodule

// ===== tb/btseq_buf.sv
`timescale 1ns/1ps
// model of the character buffer and host receiver beside the sequencer
module btseq_buf (
	// clock
	input  wire logic       pclk,
	// buffer port
	input  wire logic [6:0] buf_col,
	input  wire logic [4:0] buf_row,
	output logic      [7:0] buf_rdata,
	output logic            buf_is_fac,
	output logic            buf_fac_xmit,
	input  wire logic       store_strobe,
	input  wire logic [7:0] store_data,
	// receiver
	input  wire logic       transmit_strobe,
	input  wire logic [7:0] tx_char
);
	logic [7:0] mem [24][80];
	logic [7:0] rxq [$];
	logic       in_page;
	// positions off the page read as nul
	assign in_page      = (buf_row < 5'h18) && (buf_col < 7'h50);
	assign buf_rdata    = in_page ? mem[buf_row][buf_col] : 8'h00;
	// field codes carry bit 7, bit 6 marks a transmittable field
	assign buf_is_fac   = buf_rdata[7];
	assign buf_fac_xmit = buf_rdata[6];
	// no backpressure: every transmit strobe is taken, in order; a store strobe off the page is dropped
	always @(posedge pclk) begin
		if (store_strobe && in_page)
			mem[buf_row][buf_col] <= store_data;
		if (transmit_strobe)
			rxq.push_back(tx_char);
	end
	task clear();
		for (int r = 0; r < 24; r++)
			for (int c = 0; c < 80; c++)
				mem[r][c] = 8'h00;
		rxq.delete();
	endtask
	task put(input int r, input int c, input logic [7:0] v);
		mem[r][c] = v;
	endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
// self-checking bench of the buffer transmit sequencer
module tb import btseq_pkg::*; ;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, buf_rdata, store_data, tx_char, e;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0] buf_col;
	logic [4:0] buf_row, r;
	logic buf_is_fac, buf_fac_xmit, store_strobe, transmit_strobe;
	logic [7:0] d [5];
	logic [7:0] ex [$];
	logic [6:0] tc [4] = '{7'h4F, 7'h05, 7'h05, 7'h00};
	logic [4:0] tr [4] = '{5'h17, 5'h0B, 5'h0B, 5'h00};
	logic       tm [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	int mismatches, checked, seed;
	always #20 pclk = ~pclk;
	btseq_top btseq_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .buf_col(buf_col),
		.buf_row(buf_row), .buf_rdata(buf_rdata), .buf_is_fac(buf_is_fac),
		.buf_fac_xmit(buf_fac_xmit), .store_strobe(store_strobe),
		.store_data(store_data), .transmit_strobe(transmit_strobe), .tx_char(tx_char));
	btseq_buf btseq_buf_inst (.pclk(pclk), .buf_col(buf_col), .buf_row(buf_row),
		.buf_rdata(buf_rdata), .buf_is_fac(buf_is_fac), .buf_fac_xmit(buf_fac_xmit),
		.store_strobe(store_strobe), .store_data(store_data),
		.transmit_strobe(transmit_strobe), .tx_char(tx_char));
	task close_out();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bounded wait for a store strobe, then let the buffer write settle
	task wait_store();
		int n;
		n = 0;
		while (store_strobe !== 1'b1 && n < 3000) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 3000) begin
			mismatches++;
			close_out();
		end
		@(posedge pclk);
		@(negedge pclk);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			close_out();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// a transfer is at least three phases, so skip past the first move edge
	task run(input logic [31:0] cmd, input logic [6:0] c, input logic [4:0] rr);
		int n;
		apb(1'b1, ADDR_CURSOR, {19'h0, rr, 1'b0, c});
		apb(1'b1, ADDR_CMD, cmd);
		repeat (6) @(posedge pclk);
		for (n = 0; n < 3000; n++) begin
			apb(1'b0, ADDR_STATUS, 32'h0);
			if (rd[3:0] === 4'h8)
				break;
		end
		if (n >= 3000) begin
			mismatches++;
			close_out();
		end
		chk(btseq_buf_inst.rxq.size(), ex.size());
		foreach (ex[i])
			chk({24'h0, btseq_buf_inst.rxq[i]}, {24'h0, ex[i]});
		btseq_buf_inst.clear();
	endtask
	function logic [7:0] rch();
		rch = 8'h21 + 8'($unsigned($random(seed)) % 94);
	endfunction
	function logic [3:0] flags(input logic [6:0] c, input logic [4:0] rr, input logic m);
		flags = {c == LAST_COL, c == 7'h00, rr == (m ? LAST_ROW_12 : LAST_ROW_24), rr == 5'h00};
	endfunction
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mismatches = 0;
		checked = 0;
		seed = 32'hdc9e5d29;
		btseq_buf_inst.clear();
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CFG, 32'h0);
		chk(rd, {16'h0, END_CHAR_RST, 8'h00});
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk({23'h0, rd[8:0]}, {23'h0, flags(7'h00, 5'h00, 1'b0), 5'h08});
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, err}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, ADDR_CFG, {30'h0, tm[i], 1'b0});
			apb(1'b1, ADDR_CURSOR, {19'h0, tr[i], 1'b0, tc[i]});
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk({28'h0, rd[8:5]}, {28'h0, flags(tc[i], tr[i], tm[i])});
			chk({20'h0, buf_row, buf_col}, {20'h0, tr[i], tc[i]});
		end
		// plain send between two separators
		e = rch();
		r = 5'h01 + 5'($unsigned($random(seed)) % 20);
		foreach (d[i])
			d[i] = rch();
		apb(1'b1, ADDR_CFG, {16'h0, e, 8'h00});
		btseq_buf_inst.put(r, 1, CH_ETX);
		for (int i = 0; i < 3; i++)
			btseq_buf_inst.put(r, 2 + i, d[i]);
		btseq_buf_inst.put(r, 5, CH_ETX);
		ex = '{d[0], d[1], d[2], e};
		run(32'h1, 7'h05, r);
		apb(1'b0, ADDR_TXLAST, 32'h0);
		chk(rd, {24'h0, e});
		// home reached with no separator before it
		btseq_buf_inst.put(0, 0, d[3]);
		btseq_buf_inst.put(0, 1, d[4]);
		btseq_buf_inst.put(0, 2, CH_ETX);
		ex = '{d[3], d[4], e};
		run(32'h1, 7'h02, 5'h00);
		// separator in the last column: wrap down instead of a right step
		btseq_buf_inst.put(r, 79, CH_ETX);
		btseq_buf_inst.put(r + 1, 1, d[1]);
		btseq_buf_inst.put(r + 1, 2, CH_ETX);
		ex = '{CH_LOWER_O, d[1], e};
		run(32'h1, 7'h02, r + 5'h01);
		// keyboard enter over a line end with line feed configured
		apb(1'b1, ADDR_CFG, {16'h0, e, 8'h01});
		btseq_buf_inst.put(r, 76, CH_ETX);
		for (int i = 0; i < 3; i++)
			btseq_buf_inst.put(r, 77 + i, d[i]);
		btseq_buf_inst.put(r + 1, 1, d[3]);
		btseq_buf_inst.put(r + 1, 2, d[4]);
		ex = '{d[0], d[1], d[2], CH_CR, CH_LF, CH_LOWER_O, d[3], d[4], e};
		fork
			run(32'h6, 7'h03, r + 5'h01);
			begin
				wait_store();
				chk({24'h0, btseq_buf_inst.mem[r + 1][3]}, {24'h0, CH_ETX});
				wait_store();
				chk({24'h0, btseq_buf_inst.mem[r + 1][0]}, {24'h0, CH_LOWER_O});
			end
		join
		chk({25'h0, buf_col}, 32'h0);
		// transmittable then hidden field
		apb(1'b1, ADDR_CFG, {16'h0, e, 8'h00});
		btseq_buf_inst.put(r, 10, CH_ETX);
		btseq_buf_inst.put(r, 11, 8'hC1);
		btseq_buf_inst.put(r, 12, d[0]);
		btseq_buf_inst.put(r, 13, 8'h81);
		btseq_buf_inst.put(r, 14, d[1]);
		btseq_buf_inst.put(r, 15, CH_ETX);
		ex = '{CH_US, 8'hC1, d[0], e};
		run(32'h2, 7'h0F, r);
		// each force bit aborts a running send
		for (int b = CMD_PAGE; b <= CMD_ESC; b++) begin
			apb(1'b1, ADDR_CURSOR, {19'h0, r, 1'b0, 7'h28});
			apb(1'b1, ADDR_CMD, 32'h1);
			repeat (12) @(posedge pclk);
			apb(1'b1, ADDR_CMD, 32'h1 << b);
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk({28'h0, rd[3:0]}, 32'h8);
			@(negedge pclk);
			if (b <= CMD_HOME)
				chk({20'h0, buf_row, buf_col}, 32'h0);
		end
		close_out();
	end
endmodule
